// ---- psr_defs.svh ----
`ifndef PSR_DEFS_SVH
`define PSR_DEFS_SVH

// ============================================================
// register geometry
`define PSR_STAGES 8
`define PSR_LAST_STAGE 7
`define PSR_CLEAR_VALUE 8'h00

// ============================================================
// pin synchroniser and snapshot buffer
`define PSR_SYNC_DEPTH 2
`define PSR_PIN_COUNT 13
`define PSR_FIFO_DEPTH 32

`endif

// ---- psr_pkg.sv ----
`include "psr_defs.svh"

package psr_pkg;

    // ============================================================
    // what one system clock cycle does to the stages
    typedef enum logic [1:0] {
        ACT_HOLD,
        ACT_LOAD,
        ACT_SHIFT,
        ACT_CLEAR
    } psr_action_e;

    typedef logic [`PSR_STAGES-1:0] psr_word_t;

endpackage

// ---- psr_stream_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// valid/ready word stream between the register core and its buffer
interface psr_stream_if #(
    parameter int WIDTH = 8
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

`default_nettype wire

// ---- psr_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "psr_defs.svh"

// ============================================================
// synchronous fifo, one write and one read port
module psr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `PSR_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst_b,
    psr_stream_if.sink fill,
    psr_stream_if.source drain
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next;
    logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
    logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
    logic [AW:0] count_reg, count_next;
    logic push;
    logic pop;

    // honest full and empty straight from the occupancy count
    assign fill.ready = (count_reg != (AW+1)'(DEPTH));
    assign drain.valid = (count_reg != '0);
    assign drain.data = mem_reg[rd_ptr_reg];

    // pointer and count bookkeeping
    always_comb begin
        push = fill.valid && fill.ready;
        pop = drain.valid && drain.ready;
        mem_next = fill.data;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        if (push) begin
            wr_ptr_next = (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
        end
        case ({push, pop})
            2'b10: count_next = count_reg + 1'b1;
            2'b01: count_next = count_reg - 1'b1;
            default: count_next = count_reg;
        endcase
    end

    // storage needs no reset; only the pointers and the count do
    always_ff @(posedge clock) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= mem_next;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
    end
endmodule // psr_fifo

`default_nettype wire

// ---- psr_shift_register.sv ----
// How it works
// - eight stages held; only the last stage drives serial_out.
// - load input low at an effective rising edge copies load_word in.
// - during a load, input bit n lands in stage n.
// - load input high: each effective edge takes serial_in into stage zero.
// - on a shift edge each stage above zero takes the old value of the one below.
// - effective clock is shift_clock OR clock_enable_n; acts on its rise only.
// - while clock_enable_n is high, edges do nothing and stages hold.
// - shift_clock and clock_enable_n are interchangeable.
// - master_clear_n low forces all stages low, overriding every input.
// - without an effective edge or clear, stages and serial_out hold.
`timescale 1ns/1ps
`default_nettype none
`include "psr_defs.svh"

module psr_shift_register #(
    parameter int STAGES = `PSR_STAGES,
    parameter int FIFO_DEPTH = `PSR_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic shift_clock,
    input wire logic clock_enable_n,
    input wire logic parallel_load_n,
    input wire logic serial_in,
    input wire logic [STAGES-1:0] load_word,
    input wire logic master_clear_n,
    output logic serial_out,
    output logic snap_valid,
    output logic [STAGES-1:0] snap_data,
    input wire logic snap_ready,
    output logic snap_room
);
    localparam int PINS = STAGES + 5;

    // ============================================================
    // timing seen from the pins
    // a pin change reaches the stages on the third system clock edge:
    // two edges for the synchroniser and one for the stage update.
    // each level of the combined clock must last one full system cycle,
    // or a short rise slips through the chain unseen.
    // clear runs through the same chain, so it acts after three
    // cycles instead of at once; the trade buys glitch immunity and
    // keeps the block in a single clock domain.

    // ============================================================
    // pin synchronisers
    // all pins share one two-flop chain so that load data, mode and
    // clock stay aligned to the same system cycle after crossing
    logic [PINS-1:0] pins_raw;
    logic [PINS-1:0] sync_a_reg, sync_a_next;
    logic [PINS-1:0] sync_b_reg, sync_b_next;

    assign pins_raw = {master_clear_n, parallel_load_n, serial_in, clock_enable_n, shift_clock, load_word};

    always_comb begin
        sync_a_next = pins_raw;
        sync_b_next = sync_a_reg;
    end

    // reset value matches idle pins: clear released, clocks high
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sync_a_reg <= {1'b1, 1'b1, 1'b0, 1'b1, 1'b1, {STAGES{1'b0}}};
            sync_b_reg <= {1'b1, 1'b1, 1'b0, 1'b1, 1'b1, {STAGES{1'b0}}};
        end else begin
            sync_a_reg <= sync_a_next;
            sync_b_reg <= sync_b_next;
        end
    end

    // ============================================================
    // synchronised pin fields, read from the second flop only
    // field order follows pins_raw, clear at the top
    logic clear_n_s;
    logic load_n_s;
    logic serial_s;
    logic enable_n_s;
    logic clock_s;
    logic [STAGES-1:0] word_s;

    assign clear_n_s = sync_b_reg[STAGES+4];
    assign load_n_s = sync_b_reg[STAGES+3];
    assign serial_s = sync_b_reg[STAGES+2];
    assign enable_n_s = sync_b_reg[STAGES+1];
    assign clock_s = sync_b_reg[STAGES];
    assign word_s = sync_b_reg[STAGES-1:0];

    // ============================================================
    // effective clock and its rising edge
    // a plain OR treats both pins alike, so either may gate the other
    logic eff_clock;
    logic eff_prev_reg, eff_prev_next;
    logic eff_rise;

    assign eff_clock = clock_s | enable_n_s;
    assign eff_rise = eff_clock & ~eff_prev_reg;

    always_comb begin
        eff_prev_next = eff_clock;
    end

    // starts high so a high clock at release is no edge,
    // and a pin left low through reset gives one clean rise later
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            eff_prev_reg <= 1'b1;
        end else begin
            eff_prev_reg <= eff_prev_next;
        end
    end

    // ============================================================
    // action decode
    // clear is checked first: it beats load, shift and the edge itself.
    // an enable going high while shift_clock is low makes a real rise
    // of the OR; the register then acts on it, as the part would
    psr_pkg::psr_action_e action;

    always_comb begin
        if (!clear_n_s) begin
            action = psr_pkg::ACT_CLEAR;
        end else if (!eff_rise) begin
            action = psr_pkg::ACT_HOLD;
        end else if (!load_n_s) begin
            action = psr_pkg::ACT_LOAD;
        end else begin
            action = psr_pkg::ACT_SHIFT;
        end
    end

    // next stage contents for a given action
    // a shift moves every bit one stage towards serial_out
    function automatic logic [STAGES-1:0] stage_update(
        input psr_pkg::psr_action_e act,
        input logic [STAGES-1:0] cur,
        input logic [STAGES-1:0] word,
        input logic bit_in
    );
        logic [STAGES-1:0] res;
        res = cur;
        case (act)
            psr_pkg::ACT_CLEAR: res = STAGES'(`PSR_CLEAR_VALUE);
            psr_pkg::ACT_LOAD: res = word;
            psr_pkg::ACT_SHIFT: res = {cur[STAGES-2:0], bit_in};
            psr_pkg::ACT_HOLD: res = cur;
            default: res = cur;
        endcase
        return res;
    endfunction

    // ============================================================
    // the stages themselves
    logic [STAGES-1:0] stages_reg, stages_next;

    always_comb begin
        stages_next = stage_update(action, stages_reg, word_s, serial_s);
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            stages_reg <= STAGES'(`PSR_CLEAR_VALUE);
        end else begin
            stages_reg <= stages_next;
        end
    end

    // top stage out, so a loaded word leaves bit seven first
    assign serial_out = stages_reg[STAGES-1];

    // ============================================================
    // snapshot stream
    // each load or shift queues the new stage contents for the user side.
    // the pins cannot be stalled, so a snapshot met by a full buffer is
    // dropped; snap_room tells the driver when that would happen
    logic snap_push_reg, snap_push_next;
    logic [STAGES-1:0] snap_word_reg, snap_word_next;

    psr_stream_if #(.WIDTH(STAGES)) fill_if ();
    psr_stream_if #(.WIDTH(STAGES)) drain_if ();

    always_comb begin
        snap_push_next = (action == psr_pkg::ACT_LOAD) || (action == psr_pkg::ACT_SHIFT);
        snap_word_next = stages_next;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            snap_push_reg <= 1'b0;
            snap_word_reg <= '0;
        end else begin
            snap_push_reg <= snap_push_next;
            snap_word_reg <= snap_word_next;
        end
    end

    assign fill_if.valid = snap_push_reg;
    assign fill_if.data = snap_word_reg;
    assign snap_room = fill_if.ready;

    // ============================================================
    // snapshot buffer
    // a refused word is lost: nothing on the pin side can wait
    psr_fifo #(
        .WIDTH(STAGES),
        .DEPTH(FIFO_DEPTH)
    ) u_snap_fifo (
        .clock(clock),
        .rst_b(rst_b),
        .fill(fill_if.sink),
        .drain(drain_if.source)
    );

    // user side of the buffer, plain valid and ready
    assign snap_valid = drain_if.valid;
    assign snap_data = drain_if.data;
    assign drain_if.ready = snap_ready;
endmodule // psr_shift_register

`default_nettype wire

// ---- psr_fifo_unused_marker_none.sv ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- psr_shift_register_properties.sv ----
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// port checker, pin latency is three clocks
module psr_sr_chk #(
    parameter int STAGES = 8,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic shift_clock,
    input wire logic clock_enable_n,
    input wire logic parallel_load_n,
    input wire logic serial_in,
    input wire logic [STAGES-1:0] load_word,
    input wire logic master_clear_n,
    input wire logic serial_out,
    input wire logic snap_valid,
    input wire logic [STAGES-1:0] snap_data,
    input wire logic snap_ready,
    input wire logic snap_room
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // combined clock as seen at the pins
    wire logic eff = shift_clock | clock_enable_n;

    property p_load;
        $rose(eff) && !parallel_load_n && master_clear_n |-> ##3 serial_out == $past(load_word[STAGES-1], 3);
    endproperty
    a_load: assert property (p_load) else $error("load did not reach serial_out");
    property p_swap;
        $rose(clock_enable_n) && !shift_clock && !parallel_load_n && master_clear_n
            |-> ##3 serial_out == $past(load_word[STAGES-1], 3);
    endproperty
    a_swap: assert property (p_swap) else $error("enable pin used as clock failed");
    property p_clear; !master_clear_n [*3] |=> serial_out == 1'h0; endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero serial_out");
    property p_hold;
        $changed(serial_out) |-> ($past(eff, 3) && !$past(eff, 4)) || !$past(master_clear_n, 3);
    endproperty
    a_hold: assert property (p_hold) else $error("serial_out moved without a cause");
    property p_inhibit; (clock_enable_n && master_clear_n) [*5] |-> $stable(serial_out); endproperty
    a_inhibit: assert property (p_inhibit) else $error("serial_out moved while inhibited");
    property p_push; $rose(eff) && master_clear_n |-> ##[3:5] snap_valid; endproperty
    a_push: assert property (p_push) else $error("no snapshot after an edge");
    property p_stall; snap_valid && !snap_ready |=> snap_valid && $stable(snap_data); endproperty
    a_stall: assert property (p_stall) else $error("snapshot lost while stalled");
    property p_full; !snap_room |-> snap_valid; endproperty
    a_full: assert property (p_full) else $error("full buffer reports empty");
endmodule // psr_sr_chk

bind psr_shift_register psr_sr_chk #(.STAGES(STAGES), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clock, .rst_b,
    .shift_clock, .clock_enable_n, .parallel_load_n, .serial_in, .load_word, .master_clear_n,
    .serial_out, .snap_valid, .snap_data, .snap_ready, .snap_room);

`default_nettype wire

// ---- psr_pin_driver.sv ----
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// controlling logic on the pin side, changes at falling edges
module psr_pin_driver (
    input wire logic clock,
    output logic shift_clock,
    output logic clock_enable_n,
    output logic parallel_load_n,
    output logic serial_in,
    output psr_pkg::psr_word_t load_word,
    output logic master_clear_n
);
    // idle levels, no edge pending
    initial begin
        shift_clock = 1'h1;
        clock_enable_n = 1'h1;
        parallel_load_n = 1'h1;
        serial_in = 1'h0;
        load_word = 8'h00;
        master_clear_n = 1'h1;
    end

    // three clocks per level so the synchroniser never misses one
    task automatic pulse(input logic ld, input logic si, input psr_pkg::psr_word_t w, input bit swap);
        @(negedge clock);
        parallel_load_n = ld;
        serial_in = si;
        load_word = w;
        shift_clock = 1'h0;
        clock_enable_n = 1'h0;
        repeat (3) @(negedge clock);
        if (swap) clock_enable_n = 1'h1;
        else shift_clock = 1'h1;
        repeat (3) @(negedge clock);
    endtask

    // enable goes up only with the clock high
    task automatic inhibit;
        @(negedge clock);
        shift_clock = 1'h1;
        repeat (3) @(negedge clock);
        clock_enable_n = 1'h1;
        repeat (4) begin
            repeat (3) @(negedge clock);
            shift_clock = ~shift_clock;
        end
        repeat (3) @(negedge clock);
    endtask

    task automatic clear;
        @(negedge clock);
        master_clear_n = 1'h0;
        repeat (5) @(negedge clock);
        master_clear_n = 1'h1;
        repeat (3) @(negedge clock);
    endtask
endmodule // psr_pin_driver

`default_nettype wire

// ---- piso_shift_register_8bit_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// bench with integer model of the stages
module piso_shift_register_8bit_tb;
    localparam int FD = 4;
    logic clock = 1'h0;
    logic rst_b = 1'h0;
    logic rdy_en = 1'h1;
    logic snap_ready = 1'h0;
    wire logic sclk, cen, pln, sin, mcn, sout, sval, sroom, sout2;
    wire psr_pkg::psr_word_t lw, sdat;
    int err_total = 0;
    int checks_done = 0;
    int st = 0;
    int st2 = 0;
    psr_pkg::psr_word_t exp_q[$];

    always #12.5 clock = ~clock;

    psr_shift_register #(.FIFO_DEPTH(FD)) dut (.clock(clock), .rst_b(rst_b), .shift_clock(sclk),
        .clock_enable_n(cen), .parallel_load_n(pln), .serial_in(sin), .load_word(lw),
        .master_clear_n(mcn), .serial_out(sout), .snap_valid(sval), .snap_data(sdat),
        .snap_ready(snap_ready), .snap_room(sroom));
    psr_pin_driver drv (.clock(clock), .shift_clock(sclk), .clock_enable_n(cen),
        .parallel_load_n(pln), .serial_in(sin), .load_word(lw), .master_clear_n(mcn));
    // second device fed from the first, as a longer chain is wired
    psr_shift_register #(.FIFO_DEPTH(FD)) dut_next (.clock(clock), .rst_b(rst_b), .shift_clock(sclk),
        .clock_enable_n(cen), .parallel_load_n(pln), .serial_in(sout), .load_word(lw),
        .master_clear_n(mcn), .serial_out(sout2), .snap_valid(), .snap_data(),
        .snap_ready(1'b1), .snap_room());

    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_word(input psr_pkg::psr_word_t got, input psr_pkg::psr_word_t exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: snapshot %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // one edge on the model, then on the pins; a full buffer drops
    task automatic step(input logic ld, input bit swap);
        logic si;
        psr_pkg::psr_word_t w;
        si = 1'($urandom_range(1));
        w = 8'($urandom);
        // chained device takes the old top bit of the first one
        if (!ld) st2 = w;
        else st2 = ((st2 << 1) | st[7]) & 8'hFF;
        if (!ld) st = w;
        else st = ((st << 1) | si) & 8'hFF;
        if (exp_q.size() < FD) exp_q.push_back(st[7:0]);
        drv.pulse(ld, si, w, swap);
        chk_bit(sout, st[7]);
        chk_bit(sout2, st2[7]);
    endtask

    // random stalls on the snapshot side
    always @(negedge clock) snap_ready <= rdy_en && $urandom_range(1);

    // every popped snapshot against the model queue
    always @(posedge clock) begin
        if (rst_b && sval === 1'h1 && snap_ready) chk_word(sdat, exp_q.size() ? exp_q.pop_front() : 8'hXX);
    end

    initial begin
        void'($urandom(27));
        repeat (4) @(negedge clock);
        rst_b = 1'h1;
        repeat (3) @(negedge clock);
        chk_bit(sout, 1'h0);
        for (int i = 0; i < 40; i++) step(i % 9 != 0 && i != 1, i % 5 == 4);
        drv.inhibit();
        chk_bit(sout, st[7]);
        chk_bit(sout2, st2[7]);
        drv.clear();
        st = 0;
        st2 = 0;
        chk_bit(sout, 1'h0);
        chk_bit(sout2, 1'h0);
        repeat (10) @(negedge clock);
        rdy_en = 1'h0;
        repeat (FD + 2) step(1'h1, 1'b0);
        chk_bit(sroom, 1'h0);
        rdy_en = 1'h1;
        repeat (30) @(negedge clock);
        chk_bit(sval, 1'h0);
        chk_bit(sroom, 1'h1);
        chk_bit(exp_q.size() == 0, 1'h1);
        print_verdict();
    end

    // watchdog, the sequence needs under a thousand clocks
    initial begin
        repeat (5000) @(posedge clock);
        err_total++;
        print_verdict();
    end
endmodule // piso_shift_register_8bit_tb

`default_nettype wire
